//--- src/tic_capture.sv
// three channel input capture with shared 16-bit time base, APB slave.
// assumes capture pins are synchronous to CLK_IN; one zero-wait APB slave.
`default_nettype none

// Contract
// - three independent channels latch the 16-bit time base on their event
// - each channel has its own prescaler and an optional input noise filter
// - all channels latch and reset the one shared time base counter
// - control: reset-enable bit 6, mode bits 3..0, others read zero
// - outside pulse-width modes, reset-enable one resets time base on capture or trigger, zero leaves it running
// - mode 0000 is off; codes 1001 to 1101 do nothing
// - edge modes: falling, rising, every fourth or sixteenth rising edge
// - period mode latches on rising edges, optional reset same cycle
// - mode 1000 latches on every input change
// - pulse-width modes always reset on start edge, capture on opposite
// - entering pulse-width mode, first edge of either kind is captured
// - first capture after a mode write always stores the time base
// - sampled pin loads buffer two cycles later, reset in that same cycle
// - software time base write wins over capture reset
// - buffers take the incremented time base value
// - reset follows the latch, so captured value is never the reset
// - writing mode 0000 clears the prescaler count
// - other mode changes leave the prescaler count unchanged
// - channel one only: 1111 trigger on rising, 1110 on falling edge
// - trigger modes pulse the trigger but set no capture flag
// - encoder enable takes precedence and blocks all capture
// - each capture event sets its own channel's flag
module tic_capture #(
    parameter int FILTER_LEN = tic_pkg::FILTER_CYCLES
) (
    input wire logic CLK_IN, // 50 MHz clock
    input wire logic RST_N_IN, // synchronous reset, active low
    input wire logic PSEL_IN, // apb select
    input wire logic PENABLE_IN, // apb enable
    input wire logic PWRITE_IN, // apb direction
    input wire logic [7:0] PADDR_IN, // apb byte address
    input wire logic [31:0] PWDATA_IN, // apb write data
    output logic [31:0] PRDATA_OUT, // apb read data
    output logic PREADY_OUT, // apb ready
    output logic PSLVERR_OUT, // apb error, unmapped address
    input wire logic [2:0] CAPTURE_PIN_IN, // capture pins one to three
    output logic TRIGGER_OUT, // special event trigger pulse
    output logic [2:0] CAPTURE_FLAG_OUT // sticky capture flags
);
    localparam int FW = $clog2(FILTER_LEN + 1);

    tic_pkg::tic_ctrl_t ctrl [3];
    logic [3:0] presc [3];
    logic [2:0] first;
    logic [15:0] cap_buf [3];
    logic [15:0] time_base;
    logic [4:0] cfg;
    logic [2:0] flags;
    logic [2:0] samp;
    logic [2:0] filt;
    logic [2:0] prev;
    logic [FW-1:0] fcnt [3];
    logic [2:0] cap;
    logic [2:0] rst;
    logic trig;
    logic [3:0] next_presc [3];
    logic [15:0] tb_inc;
    logic wr;
    logic [31:0] rdata;
    logic hit;

    function automatic logic [3:0] step(input logic [3:0] cnt, input logic [3:0] last);
        step = (cnt == last) ? 4'h0 : cnt + 4'h1;
    endfunction : step

    assign wr = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
    assign tb_inc = time_base + 16'h0001;

    // pin sample and optional noise filter
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            samp <= 3'h0;
            filt <= 3'h0;
            prev <= 3'h0;
            for (int i = 0; i < 3; i++)
            begin
                fcnt[i] <= '0;
            end
        end
        else
        begin
            samp <= CAPTURE_PIN_IN;
            prev <= filt;
            for (int i = 0; i < 3; i++)
            begin
                if (!cfg[tic_pkg::CFG_FILTER_LSB + i] || samp[i] == filt[i])
                begin
                    fcnt[i] <= '0;
                    filt[i] <= samp[i];
                end
                else if (fcnt[i] == FW'(FILTER_LEN - 1))
                begin
                    fcnt[i] <= '0;
                    filt[i] <= samp[i];
                end
                else
                begin
                    fcnt[i] <= fcnt[i] + FW'(1);
                end
            end
        end
    end

    // event decode per channel
    always_comb
    begin
        logic rise;
        logic fall;
        rise = 1'b0;
        fall = 1'b0;
        trig = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            rise = filt[i] & ~prev[i] & ~cfg[tic_pkg::CFG_ENCODER_BIT];
            fall = ~filt[i] & prev[i] & ~cfg[tic_pkg::CFG_ENCODER_BIT];
            cap[i] = 1'b0;
            rst[i] = 1'b0;
            next_presc[i] = presc[i];
            case (ctrl[i].mode)
                tic_pkg::M_FALL:
                begin
                    cap[i] = fall;
                end
                tic_pkg::M_RISE, tic_pkg::M_PERIOD:
                begin
                    cap[i] = rise;
                end
                tic_pkg::M_RISE4:
                begin
                    cap[i] = rise & (presc[i] == tic_pkg::PRESC_LAST4);
                    if (rise)
                        next_presc[i] = step(presc[i], tic_pkg::PRESC_LAST4);
                end
                tic_pkg::M_RISE16:
                begin
                    cap[i] = rise & (presc[i] == tic_pkg::PRESC_LAST16);
                    if (rise)
                        next_presc[i] = step(presc[i], tic_pkg::PRESC_LAST16);
                end
                tic_pkg::M_PW_FR:
                begin
                    cap[i] = first[i] ? (rise | fall) : rise;
                    rst[i] = fall;
                end
                tic_pkg::M_PW_RF:
                begin
                    cap[i] = first[i] ? (rise | fall) : fall;
                    rst[i] = rise;
                end
                tic_pkg::M_CHANGE:
                begin
                    cap[i] = rise | fall;
                end
                tic_pkg::M_TRIG_FALL:
                begin
                    if (i == 0)
                        trig = fall;
                end
                tic_pkg::M_TRIG_RISE:
                begin
                    if (i == 0)
                        trig = rise;
                end
                default:
                begin
                    cap[i] = 1'b0;
                end
            endcase
            if (ctrl[i].mode != tic_pkg::M_PW_FR && ctrl[i].mode != tic_pkg::M_PW_RF)
                rst[i] = (cap[i] | (i == 0 && trig)) & ctrl[i].ren;
        end
    end

    // control registers, prescalers, first-edge marks
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            for (int i = 0; i < 3; i++)
            begin
                ctrl[i].ren <= tic_pkg::REN_RESET;
                ctrl[i].mode <= tic_pkg::MODE_RESET;
                presc[i] <= 4'h0;
            end
            first <= 3'h0;
            cfg <= tic_pkg::CONFIG_RESET;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                presc[i] <= next_presc[i];
                if (cap[i])
                    first[i] <= 1'b0;
                if (wr && PADDR_IN == tic_pkg::OFF_CTRL1 + 8'(4 * i))
                begin
                    ctrl[i].ren <= PWDATA_IN[tic_pkg::REN_BIT];
                    ctrl[i].mode <= PWDATA_IN[tic_pkg::MODE_LSB +: tic_pkg::MODE_W];
                    first[i] <= 1'b1;
                    if (PWDATA_IN[tic_pkg::MODE_LSB +: tic_pkg::MODE_W] == tic_pkg::M_OFF)
                        presc[i] <= 4'h0;
                    // other writes keep the prescaler count
                end
            end
            if (wr && PADDR_IN == tic_pkg::OFF_CONFIG)
                cfg <= PWDATA_IN[4:0];
        end
    end

    // shared time base and capture buffers
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            time_base <= tic_pkg::TIMEBASE_RESET;
            for (int i = 0; i < 3; i++)
            begin
                cap_buf[i] <= 16'h0000;
            end
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (cap[i])
                    cap_buf[i] <= tb_inc;
            end
            if (wr && PADDR_IN == tic_pkg::OFF_TIMEBASE)
                time_base <= PWDATA_IN[15:0];
            else if (|rst)
                time_base <= 16'h0000;
            else if (cfg[tic_pkg::CFG_RUN_BIT])
                time_base <= tb_inc;
        end
    end

    // flags and trigger
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            flags <= 3'h0;
            TRIGGER_OUT <= 1'b0;
        end
        else
        begin
            TRIGGER_OUT <= trig;
            for (int i = 0; i < 3; i++)
            begin
                if (cap[i])
                    flags[i] <= 1'b1;
                else if (wr && PADDR_IN == tic_pkg::OFF_STATUS && PWDATA_IN[i])
                    flags[i] <= 1'b0;
            end
        end
    end

    assign CAPTURE_FLAG_OUT = flags;

    // read decode
    always_comb
    begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        if (PADDR_IN == tic_pkg::OFF_CTRL1)
            rdata = {25'h0, ctrl[0].ren, 2'h0, ctrl[0].mode};
        else if (PADDR_IN == tic_pkg::OFF_CTRL2)
            rdata = {25'h0, ctrl[1].ren, 2'h0, ctrl[1].mode};
        else if (PADDR_IN == tic_pkg::OFF_CTRL3)
            rdata = {25'h0, ctrl[2].ren, 2'h0, ctrl[2].mode};
        else if (PADDR_IN == tic_pkg::OFF_BUF1)
            rdata = {16'h0, cap_buf[0][15:8], cap_buf[0][7:0]};
        else if (PADDR_IN == tic_pkg::OFF_BUF2)
            rdata = {16'h0, cap_buf[1][15:8], cap_buf[1][7:0]};
        else if (PADDR_IN == tic_pkg::OFF_BUF3)
            rdata = {16'h0, cap_buf[2][15:8], cap_buf[2][7:0]};
        else if (PADDR_IN == tic_pkg::OFF_TIMEBASE)
            rdata = {16'h0, time_base};
        else if (PADDR_IN == tic_pkg::OFF_STATUS)
            rdata = {29'h0, flags};
        else if (PADDR_IN == tic_pkg::OFF_CONFIG)
            rdata = {27'h0, cfg};
        else
            hit = 1'b0;
    end

    // apb answer: ready in the first access cycle
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
        end
        else
        begin
            PREADY_OUT <= PSEL_IN & ~PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN & ~PENABLE_IN & ~hit;
            if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
                PRDATA_OUT <= rdata;
        end
    end
endmodule : tic_capture
`default_nettype wire

//--- src/tic_pkg.sv
// package for the three channel input capture block: register map,
// control layout, mode codes and reset values.
// assumes a 32-bit APB master and one 50 MHz clock.
`default_nettype none
package tic_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_CTRL3 = 8'h08;
    localparam logic [7:0] OFF_BUF1 = 8'h0C;
    localparam logic [7:0] OFF_BUF2 = 8'h10;
    localparam logic [7:0] OFF_BUF3 = 8'h14;
    localparam logic [7:0] OFF_TIMEBASE = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_CONFIG = 8'h20;

    // control register field positions
    localparam int REN_BIT = 6;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;

    // config register field positions
    localparam int CFG_FILTER_LSB = 0;
    localparam int CFG_ENCODER_BIT = 3;
    localparam int CFG_RUN_BIT = 4;

    // reset values
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic REN_RESET = 1'b0;
    localparam logic [15:0] TIMEBASE_RESET = 16'h0000;
    localparam logic [4:0] CONFIG_RESET = 5'h10;

    // noise filter: input must hold this many cycles
    localparam int FILTER_CYCLES = 3;

    // mode codes
    localparam logic [3:0] M_OFF = 4'h0;
    localparam logic [3:0] M_FALL = 4'h1;
    localparam logic [3:0] M_RISE = 4'h2;
    localparam logic [3:0] M_RISE4 = 4'h3;
    localparam logic [3:0] M_RISE16 = 4'h4;
    localparam logic [3:0] M_PERIOD = 4'h5;
    localparam logic [3:0] M_PW_FR = 4'h6;
    localparam logic [3:0] M_PW_RF = 4'h7;
    localparam logic [3:0] M_CHANGE = 4'h8;
    localparam logic [3:0] M_TRIG_FALL = 4'hE;
    localparam logic [3:0] M_TRIG_RISE = 4'hF;

    // prescaler terminal counts
    localparam logic [3:0] PRESC_LAST4 = 4'h3;
    localparam logic [3:0] PRESC_LAST16 = 4'hF;

    typedef struct packed {
        logic ren;
        logic [3:0] mode;
    } tic_ctrl_t;
endpackage : tic_pkg
`default_nettype wire

//--- test/tb.sv
// self-checking bench for tic_capture with an edge source on the pins.
// assumes zero-wait apb answers and the filter left off outside the config test.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, trig;
    logic [2:0] want = 3'h0, pins, flags;
    int err_total = 0, n_checks = 0, trig_seen = 0;
    always #10 clk = ~clk;
    always @(posedge clk)
        if (trig === 1'b1) trig_seen++;
    tic_capture dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CAPTURE_PIN_IN(pins),
        .TRIGGER_OUT(trig), .CAPTURE_FLAG_OUT(flags));
    tic_edge_src src_u (.clk_in(clk), .want_in(want), .pin_out(pins));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic cap(input int c, m, ren, lv, hit, rs, tg);
        int t0;
        t0 = trig_seen;
        apb(1'b1, 8'(4 * c), 32'h0);
        want[c] <= 1'(lv == 0);
        repeat (3) @(posedge clk);
        apb(1'b1, 8'(4 * c), {25'h0, 1'(ren), 2'h0, 4'(m)});
        apb(1'b1, 8'h1C, 32'h7);
        apb(1'b1, 8'h18, 32'h1000);
        want[c] <= 1'(lv);
        repeat (6) @(posedge clk);
        cmp({29'h0, flags}, 32'(hit << c));
        apb(1'b0, 8'(12 + 4 * c), 32'h0);
        if (hit != 0)
            cmp(rd, 32'h0000_1005);
        apb(1'b0, 8'h18, 32'h0);
        cmp(32'(rd < 32'h40), 32'(rs));
        cmp(32'(trig_seen - t0), 32'(tg));
        $display("test capture mode %0d done", m);
    endtask : cap
    task automatic flip(input int n);
        repeat (n)
        begin
            want[1] <= ~want[1];
            repeat (5) @(posedge clk);
        end
    endtask : flip
    task automatic t_regs;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            cmp(rd, 32'h0);
        end
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        apb(1'b0, 8'h08, 32'h0);
        cmp(rd, 32'h0000_004F);
        apb(1'b0, 8'h40, 32'h0);
        cmp({31'h0, er}, 32'h1);
        $display("test registers done");
    endtask : t_regs
    task automatic t_presc;
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h04, 32'h3);
        flip(4);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h04, 32'h3);
        apb(1'b1, 8'h1C, 32'h7);
        flip(6);
        cmp({29'h0, flags}, 32'h0);
        flip(2);
        cmp({29'h0, flags}, 32'h2);
        $display("test prescaler done");
    endtask : t_presc
    task automatic t_cfg;
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h08, 32'h8);
        apb(1'b1, 8'h20, 32'h18);
        apb(1'b1, 8'h1C, 32'h7);
        want[2] <= ~want[2];
        repeat (6) @(posedge clk);
        cmp({29'h0, flags}, 32'h0);
        apb(1'b1, 8'h20, 32'h14);
        want[2] <= ~want[2];
        @(posedge clk);
        want[2] <= ~want[2];
        repeat (8) @(posedge clk);
        cmp({29'h0, flags}, 32'h0);
        apb(1'b1, 8'h20, 32'h10);
        want[2] <= ~want[2];
        repeat (6) @(posedge clk);
        cmp({29'h0, flags}, 32'h4);
        $display("test config done");
    endtask : t_cfg
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        cap(0, 1, 0, 0, 1, 0, 0);
        cap(1, 1, 1, 1, 0, 0, 0);
        cap(2, 2, 1, 1, 1, 1, 0);
        cap(0, 3, 0, 1, 0, 0, 0);
        cap(1, 4, 0, 1, 0, 0, 0);
        cap(2, 5, 1, 1, 1, 1, 0);
        cap(0, 6, 0, 0, 1, 1, 0);
        cap(1, 7, 0, 0, 1, 0, 0);
        cap(2, 8, 1, 0, 1, 1, 0);
        cap(0, 9, 1, 1, 0, 0, 0);
        cap(1, 0, 1, 1, 0, 0, 0);
        cap(0, 15, 1, 1, 0, 1, 1);
        cap(0, 14, 0, 0, 0, 0, 1);
        cap(1, 15, 0, 1, 0, 0, 0);
        t_presc();
        t_cfg();
        final_report();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        final_report();
    end
endmodule : tb
`default_nettype wire

//--- test/tic_capture_props.sv
// port checker for tic_capture, bound to it below.
// assumes the capture input filter stays off.
`default_nettype none
module tic_capture_props #(
    parameter int FILTER_LEN = 3
) (
    input wire logic CLK_IN, // clock
    input wire logic RST_N_IN, // reset
    input wire logic PSEL_IN, // select
    input wire logic PENABLE_IN, // enable
    input wire logic PWRITE_IN, // direction
    input wire logic [7:0] PADDR_IN, // address
    input wire logic [31:0] PRDATA_OUT, // read data
    input wire logic PREADY_OUT, // ready
    input wire logic [2:0] CAPTURE_PIN_IN, // pins
    input wire logic TRIGGER_OUT, // trigger
    input wire logic [2:0] CAPTURE_FLAG_OUT // flags
);
    timeunit 1ns;
    timeprecision 1ns;
    wire rd_ok = PREADY_OUT && !PWRITE_IN;
    default clocking @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    chk_ready_first: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
        else $error("no ready in first access cycle");
    chk_ready_single: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    chk_ctrl_zero: assert property (rd_ok && PADDR_IN < 8'h0C
        |-> (PRDATA_OUT & 32'hFFFF_FFB0) == 32'h0) else $error("control pad bits set");
    chk_buf_width: assert property (rd_ok && PADDR_IN inside {8'h0C, 8'h10, 8'h14}
        |-> PRDATA_OUT[31:16] == 16'h0) else $error("buffer upper bits set");
    chk_flag_cause: assert property (((CAPTURE_FLAG_OUT & ~$past(CAPTURE_FLAG_OUT))
        & ~($past(CAPTURE_PIN_IN, 3) ^ $past(CAPTURE_PIN_IN, 4))) == 3'h0)
        else $error("flag without pin change");
    chk_trig_cause: assert property (TRIGGER_OUT
        |-> $past(CAPTURE_PIN_IN[0], 3) != $past(CAPTURE_PIN_IN[0], 4)) else $error("stray trigger");
    chk_trig_noflag: assert property (TRIGGER_OUT |-> !$rose(CAPTURE_FLAG_OUT[0]))
        else $error("trigger set a flag");
    chk_reset_clear: assert property ($rose(RST_N_IN)
        |-> CAPTURE_FLAG_OUT == 3'h0 && !TRIGGER_OUT) else $error("outputs not cleared");
    cover property (TRIGGER_OUT);
    cover property ($rose(CAPTURE_FLAG_OUT[2]));
    cover property (rd_ok && PADDR_IN == 8'h0C);
endmodule : tic_capture_props
bind tic_capture tic_capture_props #(.FILTER_LEN(FILTER_LEN)) chk_u (.CLK_IN(CLK_IN),
    .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
    .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .CAPTURE_PIN_IN(CAPTURE_PIN_IN), .TRIGGER_OUT(TRIGGER_OUT),
    .CAPTURE_FLAG_OUT(CAPTURE_FLAG_OUT));
`default_nettype wire

//--- test/tic_edge_src.sv
// edge source standing in for sensors on the three capture pins.
// assumes requests change right after a rising clock edge.
`default_nettype none
module tic_edge_src (
    input wire logic clk_in, // clock
    input wire logic [2:0] want_in, // requested pin levels
    output logic [2:0] pin_out // capture pins, one clock later
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk_in)
        pin_out <= want_in;
endmodule : tic_edge_src
`default_nettype wire
